//--- scc_pkg.sv
// Notes on behaviour
// - receive enable raises interrupt on full/fault
// - disable aborts, empties buffers, keeps fault flag
// - transmit enable raises interrupt while empty
// - control one bit four picks role
// - bit three sets clock idle level
// - bit two sets first edge position
// - select pin function follows role, fault, output
// - bit zero sets first shifted bit
// - control two bits 7,6,5,2 read zero
// - fault enable ignored while slave
// - bidir output enable drives shared pin
// - bidir enable ignored with separate pins
// - stop in wait freezes engine
// - pin control selects single shared wire
// - control one readable and writable
// - master drives clock, roles swap data pins
// - disabled port releases all four pins
package scc_pkg;
	// ==========================================
	// register map
	localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
	localparam logic [2:0] ADDR_STATUS   = 3'h2;
	localparam logic [2:0] ADDR_DATA     = 3'h3;
	localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
	// ==========================================
	// fields and reset values
	localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST  = 8'h00;
	localparam logic [7:0] CTRL_TWO_MASK = 8'h1B;
	localparam int         ST_RX_FULL    = 7;
	localparam int         ST_TX_EMPTY   = 5;
	localparam int         ST_MODE_FAULT = 4;
	localparam int         EV_BYTE_DONE  = 0;
	localparam int         EV_TX_TAKEN   = 1;
	localparam int         EV_MODE_FAULT = 2;
	localparam logic [2:0] IRQ_RST       = 3'h0;
	localparam logic [7:0] FILL_BYTE     = 8'h00;
	localparam logic [3:0] SYNC_RST      = 4'h1;
	localparam logic [2:0] LAST_BIT      = 3'h7;
	localparam logic [3:0] LAST_HALF     = 4'hF;
	// ==========================================
	// timing
	localparam int         CLOCK_NS       = 8;
	localparam int         MASTER_HALF_NS = 80;
	localparam logic [3:0] HALF_CYC       =
		4'((MASTER_HALF_NS + CLOCK_NS - 1) / CLOCK_NS);
	// ==========================================
	// types
	typedef struct packed {
		logic receiveInterruptEnable;
		logic systemEnable;
		logic transmitInterruptEnable;
		logic masterSelect;
		logic clockPolarity;
		logic clockPhase;
		logic selectOutputEnable;
		logic lsbFirstEnable;
	} scc_ctrl_one_t;
	typedef struct packed {
		logic [2:0] spareHigh;
		logic       modeFaultEnable;
		logic       bidirOutputEnable;
		logic       spareLow;
		logic       stopInWait;
		logic       pinControlZero;
	} scc_ctrl_two_t;
	typedef struct packed {
		logic sckDrive;
		logic sckDriveEn;
		logic mosiDrive;
		logic mosiDriveEn;
		logic misoDrive;
		logic misoDriveEn;
		logic selectDriveN;
		logic selectDriveEn;
	} scc_pins_t;
	typedef enum logic {SCC_IDLE, SCC_RUN} scc_state_t;
endpackage

//--- scc_top.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module scc_top (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	input  wire logic       waitMode,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	output logic            irq,
	input  wire logic       sckSense,
	output logic            sckDrive,
	output logic            sckDriveEn,
	input  wire logic       mosiSense,
	output logic            mosiDrive,
	output logic            mosiDriveEn,
	input  wire logic       misoSense,
	output logic            misoDrive,
	output logic            misoDriveEn,
	input  wire logic       selectSenseN,
	output logic            selectDriveN,
	output logic            selectDriveEn
);
	// ==========================================
	// state
	scc_pkg::scc_ctrl_one_t c1Q;
	scc_pkg::scc_ctrl_two_t c2Q;
	scc_pkg::scc_pins_t     pinQ;
	scc_pkg::scc_pins_t     pin_d;
	scc_pkg::scc_state_t    stateQ;
	logic [3:0] sync1Q;
	logic [3:0] sync2Q;
	logic [3:0] sync3Q;
	logic [3:0] filtQ;
	logic [7:0] rxBufQ;
	logic [7:0] txBufQ;
	logic       rxFullQ;
	logic       txFullQ;
	logic       modfQ;
	logic       rxArmQ;
	logic       txArmQ;
	logic       modfArmQ;
	logic [2:0] irqStatQ;
	logic [2:0] irqMaskQ;
	logic [7:0] rdDataQ;
	logic [7:0] rd_d;
	logic       irqQ;
	logic [7:0] shiftQ;
	logic [2:0] bitCntQ;
	logic [3:0] halfQ;
	logic [3:0] timerQ;
	logic       sckQ;
	logic       outBitQ;
	logic       inBitQ;
	logic       sckPrevQ;

	// ==========================================
	// bus decode
	wire wrC1   = regWr && (regAddr == scc_pkg::ADDR_CTRL_ONE);
	wire wrC2   = regWr && (regAddr == scc_pkg::ADDR_CTRL_TWO);
	wire wrData = regWr && (regAddr == scc_pkg::ADDR_DATA);
	wire wrStat = regWr && (regAddr == scc_pkg::ADDR_IRQ_STAT);
	wire wrMask = regWr && (regAddr == scc_pkg::ADDR_IRQ_MASK);
	wire rdStat = regRd && (regAddr == scc_pkg::ADDR_STATUS);
	wire rdData = regRd && (regAddr == scc_pkg::ADDR_DATA);

	// ==========================================
	// role and pin selection
	wire en      = c1Q.systemEnable;
	wire mst     = en && c1Q.masterSelect;
	wire slv     = en && !c1Q.masterSelect;
	wire clock_polarity    = c1Q.clockPolarity;
	wire clock_phase    = c1Q.clockPhase;
	wire lsbf    = c1Q.lsbFirstEnable;
	wire pc0     = c2Q.pinControlZero;
	wire ssLow   = !filtQ[0];
	wire slvSel  = slv && ssLow;
	// fault input only as master with fault enabled and no select output
	wire modfHit = mst && c2Q.modeFaultEnable && !c1Q.selectOutputEnable && ssLow;
	wire ssAuto  = mst && c2Q.modeFaultEnable && c1Q.selectOutputEnable;
	// data input pin follows role and single-wire choice
	wire dataIn  = (mst == pc0) ? filtQ[2] : filtQ[1];
	// stop in wait freezes the shifter and its flags as well
	wire engRun  = clkEn && !(waitMode && c2Q.stopInWait);
	wire running = (stateQ == scc_pkg::SCC_RUN);

	// ==========================================
	// master edge timing
	wire timerHit = running && (timerQ == scc_pkg::HALF_CYC - 4'h1);
	wire lastHalf = (halfQ == scc_pkg::LAST_HALF);
	wire mStart   = mst && !running && txFullQ && !modfHit;
	wire mEnd     = mst && timerHit && lastHalf;
	// phase 0: first edge mid cycle; phase 1: first edge at start
	wire mLead    = mst && (clock_phase ? (mStart || (timerHit && halfQ[0] && !lastHalf))
		: (timerHit && !halfQ[0]));
	wire mTrail   = mst && timerHit && (clock_phase ? !halfQ[0] : halfQ[0]);

	// ==========================================
	// slave edge detection on the filtered clock
	wire sckF    = filtQ[3];
	wire sEdge   = slvSel && running && (sckF != sckPrevQ);
	wire sLead   = sEdge && (sckF != clock_polarity);
	wire sTrail  = sEdge && (sckF == clock_polarity);
	wire sStart  = slvSel && !running;

	// ==========================================
	// shifter datapath
	wire start     = mStart || sStart;
	wire lead      = mLead || sLead;
	wire trail     = mTrail || sTrail;
	wire byteDone  = trail && (bitCntQ == scc_pkg::LAST_BIT);
	wire sReload   = slv && byteDone;
	wire txTake    = txFullQ && (start || sReload);
	wire abort     = !en || modfHit || (running && !mst && !slvSel);
	wire sampleBit = clock_phase ? dataIn : inBitQ;
	wire [7:0] loadVal   = txFullQ ? txBufQ : scc_pkg::FILL_BYTE;
	wire [7:0] curShift  = start ? loadVal : shiftQ;
	// shift direction picks which end leaves first
	wire [7:0] shiftNext = lsbf ? {sampleBit, shiftQ[7:1]}
		: {shiftQ[6:0], sampleBit};
	wire [7:0] afterTrail = sReload ? loadVal : shiftNext;
	wire leadOut   = lsbf ? curShift[0] : curShift[7];
	wire trailOut  = lsbf ? afterTrail[0] : afterTrail[7];
	wire startOut  = lsbf ? loadVal[0] : loadVal[7];

	// ==========================================
	// pin synchroniser, three stages, change taken when 2 and 3 agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1Q <= scc_pkg::SYNC_RST;
			sync2Q <= scc_pkg::SYNC_RST;
			sync3Q <= scc_pkg::SYNC_RST;
		end else if (clkEn) begin
			sync1Q <= {sckSense, mosiSense, misoSense, selectSenseN};
			sync2Q <= sync1Q;
			sync3Q <= sync2Q;
		end
	end

	// per-bit agreement filter rejects single-sample glitches
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			filtQ <= scc_pkg::SYNC_RST;
		end else if (clkEn) begin
			for (int i = 0; i < 4; i++) begin
				if (sync2Q[i] == sync3Q[i]) begin
					filtQ[i] <= sync3Q[i];
				end
			end
		end
	end

	// ==========================================
	// control registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			c1Q <= scc_pkg::CTRL_ONE_RST;
			c2Q <= scc_pkg::CTRL_TWO_RST;
		end else if (clkEn) begin
			if (wrC1) begin
				c1Q <= regWrData;
			end
			if (wrC2) begin
				c2Q <= regWrData & scc_pkg::CTRL_TWO_MASK;
			end
		end
	end

	// interrupt mask, and sticky events where a new event beats the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqMaskQ <= scc_pkg::IRQ_RST;
			irqStatQ <= scc_pkg::IRQ_RST;
		end else if (clkEn) begin
			if (wrMask) begin
				irqMaskQ <= regWrData[2:0];
			end
			irqStatQ <= (irqStatQ & ~(wrStat ? regWrData[2:0] : 3'h0))
				| ({modfHit && !modfQ, txTake, byteDone} & {3{engRun}});
		end
	end

	// ==========================================
	// status read arms the clearing access that follows
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxArmQ   <= 1'b0;
			txArmQ   <= 1'b0;
			modfArmQ <= 1'b0;
		end else if (clkEn) begin
			if (rdStat) begin
				rxArmQ   <= rxFullQ;
				txArmQ   <= !txFullQ;
				modfArmQ <= modfQ;
			end
		end
	end

	// buffers and flags; disabling empties both buffers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxFullQ <= 1'b0;
			txFullQ <= 1'b0;
			modfQ   <= 1'b0;
			rxBufQ  <= 8'h00;
			txBufQ  <= 8'h00;
		end else if (clkEn) begin
			if (!en) begin
				rxFullQ <= 1'b0;
				txFullQ <= 1'b0;
			end else begin
				if (engRun && byteDone) begin
					rxFullQ <= 1'b1;
					rxBufQ  <= shiftNext;
				end else if (rdData && rxArmQ) begin
					rxFullQ <= 1'b0;
				end
				// unarmed data writes are dropped
				if (wrData && txArmQ) begin
					txFullQ <= 1'b1;
					txBufQ  <= regWrData;
				end else if (engRun && txTake) begin
					txFullQ <= 1'b0;
				end
			end
			if (engRun && modfHit) begin
				modfQ <= 1'b1;
			end else if (wrC1 && modfArmQ) begin
				modfQ <= 1'b0;
			end
		end
	end

	// ==========================================
	// transfer state and half-period timing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= scc_pkg::SCC_IDLE;
			timerQ <= 4'h0;
			halfQ  <= 4'h0;
		end else if (engRun) begin
			if (abort || mEnd) begin
				stateQ <= scc_pkg::SCC_IDLE;
			end else if (start) begin
				stateQ <= scc_pkg::SCC_RUN;
			end
			timerQ <= (start || timerHit) ? 4'h0 : timerQ + 4'h1;
			if (start) begin
				halfQ <= 4'h0;
			end else if (timerHit) begin
				halfQ <= halfQ + 4'h1;
			end
		end
	end

	// shifter, bit count and sampled bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shiftQ  <= 8'h00;
			bitCntQ <= 3'h0;
			inBitQ  <= 1'b0;
		end else if (engRun) begin
			if (start) begin
				shiftQ  <= loadVal;
				bitCntQ <= 3'h0;
			end else if (trail) begin
				shiftQ  <= afterTrail;
				bitCntQ <= bitCntQ + 3'h1;
			end
			if (lead && !clock_phase) begin
				inBitQ <= dataIn;
			end
		end
	end

	// output bit: phase 0 moves on trailing edges, phase 1 on leading
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outBitQ <= 1'b0;
		end else if (engRun) begin
			if (clock_phase && lead) begin
				outBitQ <= leadOut;
			end else if (!clock_phase && start) begin
				outBitQ <= startOut;
			end else if (!clock_phase && trail) begin
				outBitQ <= trailOut;
			end
		end
	end

	// master clock idles at polarity level between bytes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sckQ     <= 1'b0;
			sckPrevQ <= 1'b0;
		end else if (engRun) begin
			sckPrevQ <= sckF;
			if (!running && !mStart) begin
				sckQ <= clock_polarity;
			end else if (mLead || mTrail) begin
				sckQ <= !sckQ;
			end
		end
	end

	// ==========================================
	// pin drive: all released while disabled
	always_comb begin
		pin_d = '0;
		pin_d.selectDriveN = 1'b1;
		if (mst) begin
			pin_d.sckDrive    = sckQ;
			pin_d.sckDriveEn  = 1'b1;
			pin_d.mosiDrive   = outBitQ;
			// single wire: bidir enable decides; otherwise always driving
			pin_d.mosiDriveEn = !pc0 || c2Q.bidirOutputEnable;
			// select falls with the start strobe, at least a cycle ahead of the first clock edge at the pin
			pin_d.selectDriveN  = !(running || mStart);
			pin_d.selectDriveEn = ssAuto;
		end else if (slvSel) begin
			pin_d.misoDrive   = outBitQ;
			pin_d.misoDriveEn = !pc0 || c2Q.bidirOutputEnable;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinQ <= '0;
		end else if (clkEn) begin
			pinQ <= pin_d;
		end
	end

	// ==========================================
	// read mux, answered one cycle after the strobe
	always_comb begin
		rd_d = 8'h00;
		if (regAddr == scc_pkg::ADDR_CTRL_ONE) begin
			rd_d = c1Q;
		end else if (regAddr == scc_pkg::ADDR_CTRL_TWO) begin
			rd_d = c2Q & scc_pkg::CTRL_TWO_MASK;
		end else if (regAddr == scc_pkg::ADDR_STATUS) begin
			rd_d[scc_pkg::ST_RX_FULL]    = rxFullQ;
			rd_d[scc_pkg::ST_TX_EMPTY]   = !txFullQ;
			rd_d[scc_pkg::ST_MODE_FAULT] = modfQ;
		end else if (regAddr == scc_pkg::ADDR_DATA) begin
			rd_d = rxBufQ;
		end else if (regAddr == scc_pkg::ADDR_IRQ_STAT) begin
			rd_d[2:0] = irqStatQ;
		end else if (regAddr == scc_pkg::ADDR_IRQ_MASK) begin
			rd_d[2:0] = irqMaskQ;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdDataQ <= 8'h00;
		end else if (clkEn) begin
			rdDataQ <= regRd ? rd_d : 8'h00;
		end
	end

	// level interrupt from enabled flags and unmasked sticky events
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqQ <= 1'b0;
		end else if (clkEn) begin
			irqQ <= (c1Q.receiveInterruptEnable && (rxFullQ || modfQ))
				|| (c1Q.transmitInterruptEnable && !txFullQ)
				|| (|(irqStatQ & irqMaskQ));
		end
	end

	// ==========================================
	// outputs
	assign regRdData     = rdDataQ;
	assign irq           = irqQ;
	assign sckDrive      = pinQ.sckDrive;
	assign sckDriveEn    = pinQ.sckDriveEn;
	assign mosiDrive     = pinQ.mosiDrive;
	assign mosiDriveEn   = pinQ.mosiDriveEn;
	assign misoDrive     = pinQ.misoDrive;
	assign misoDriveEn   = pinQ.misoDriveEn;
	assign selectDriveN  = pinQ.selectDriveN;
	assign selectDriveEn = pinQ.selectDriveEn;
endmodule

//--- scc_top_chk.sv
`timescale 1ns/1ns
module scc_top_chk (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       clkEn,
	input wire logic       waitMode,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdData,
	input wire logic       irq,
	input wire logic       sckSense,
	input wire logic       sckDrive,
	input wire logic       sckDriveEn,
	input wire logic       mosiSense,
	input wire logic       mosiDrive,
	input wire logic       mosiDriveEn,
	input wire logic       misoSense,
	input wire logic       misoDrive,
	input wire logic       misoDriveEn,
	input wire logic       selectSenseN,
	input wire logic       selectDriveN,
	input wire logic       selectDriveEn
);
	logic [7:0] ctrlOne_q;
	logic [7:0] ctrlTwo_q;
	logic       en;
	logic       masterOn;
	logic       selOut;
	logic       stopNow;
	// ==========================================
	// shadow of the control writes, so the checks know the configuration
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrlOne_q <= 8'h00;
			ctrlTwo_q <= 8'h00;
		end else if (regWr && clkEn && regAddr == 3'h0) begin
			ctrlOne_q <= regWrData;
		end else if (regWr && clkEn && regAddr == 3'h1) begin
			ctrlTwo_q <= regWrData & 8'h1B;
		end
	end
	// decoded configuration
	assign en = ctrlOne_q[6];
	assign masterOn = en & ctrlOne_q[4];
	assign selOut = masterOn & ctrlTwo_q[4] & ctrlOne_q[1];
	assign stopNow = waitMode & ctrlTwo_q[1];
	// ==========================================
	// pin outputs are registered, so pin checks wait two samples, the idle-clock and wait checks three
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ctrl_one_read: assert property (regRd && clkEn && regAddr == 3'h0
		|=> regRdData == $past(ctrlOne_q)) else $error("control one readback wrong");
	a_ctrl_two_read: assert property (regRd && clkEn && regAddr == 3'h1
		|=> regRdData == $past(ctrlTwo_q)) else $error("control two readback wrong");
	a_pins_released: assert property (!en [*2]
		|-> !(sckDriveEn | mosiDriveEn | misoDriveEn | selectDriveEn))
		else $error("pin driven while disabled");
	a_master_clock: assert property (masterOn [*2]
		|-> sckDriveEn && !misoDriveEn) else $error("master pin directions wrong");
	a_select_input: assert property ((en && !selOut) [*2]
		|-> !selectDriveEn) else $error("select driven while not an output");
	a_select_output: assert property (selOut [*2]
		|-> selectDriveEn) else $error("select output not driven");
	a_bidir_drive: assert property ((masterOn && ctrlTwo_q[0]) [*2]
		|-> mosiDriveEn == ctrlTwo_q[3]) else $error("shared pin driver wrong");
	a_sep_pins: assert property ((masterOn && !ctrlTwo_q[0]) [*2]
		|-> mosiDriveEn) else $error("data out not driven");
	a_sck_idle: assert property ((selOut && selectDriveN) [*3]
		|-> sckDrive == ctrlOne_q[3]) else $error("clock idle level wrong");
	// an edge taken just before wait reaches the pin one sample late
	a_wait_freeze: assert property (stopNow [*3]
		|-> $stable(sckDrive)) else $error("clock moved in wait");
	c_frame: cover property ($fell(selectDriveN));
	c_irq: cover property ($rose(irq));
	c_wait: cover property (stopNow && masterOn);
endmodule
bind scc_top scc_top_chk chk (.clock, .rst_n, .clkEn, .waitMode, .regAddr, .regWrData,
	.regWr, .regRd, .regRdData, .irq, .sckSense, .sckDrive, .sckDriveEn, .mosiSense,
	.mosiDrive, .mosiDriveEn, .misoSense, .misoDrive, .misoDriveEn, .selectSenseN,
	.selectDriveN, .selectDriveEn);

//--- scc_peer_model.sv
`timescale 1ns/1ns
module scc_peer_model (
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic       lsb,
	input  wire logic [7:0] txByte,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       selN,
	output logic            miso,
	output logic      [7:0] rxByte
);
	logic [3:0] nBit;
	logic [2:0] idx;
	logic       sckLast;
	// ==========================================
	// bit index follows the shift order
	assign idx = lsb ? nBit[2:0] : 3'h7 - nBit[2:0];
	// released line shows the opposite level so a stale bit is never taken
	assign miso = selN ? ~txByte[idx] : txByte[idx];
	// sample on the leading edge for phase 0, on the trailing one for phase 1
	always @(sck or selN) begin
		if (selN) begin
			nBit = 4'h0;
		end else if (sck !== sckLast && sck == (clock_polarity ^ !clock_phase)) begin
			rxByte[idx] = mosi;
			nBit = nBit + 4'h1;
		end
		sckLast = sck;
	end
endmodule

//--- test_spi_control_configuration.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_spi_control_configuration;
	logic       clock, rst_n, waitMode, regWr, regRd, irq;
	logic [2:0] regAddr;
	logic [7:0] regWrData, regRdData, rdv, cfg, peerTx, peerRx;
	logic       sckDrive, sckDriveEn, mosiDrive, mosiDriveEn, misoDrive, misoDriveEn;
	logic       selectDriveN, selectDriveEn, peerMiso, clock_polarity, clock_phase, lsb;
	logic [1:0] mv;
	wire logic  sckSense, mosiSense, misoSense, selectSenseN;
	int         errors = 0;
	int         nTests = 0;
	// ==========================================
	// wire levels; select has a pull-up, the idle clock rests at polarity
	assign sckSense = sckDriveEn ? sckDrive : clock_polarity;
	assign mosiSense = mosiDriveEn ? mosiDrive : 1'h1;
	assign misoSense = misoDriveEn ? misoDrive : peerMiso;
	assign selectSenseN = selectDriveEn ? selectDriveN : 1'h1;
	scc_top uut (.clock, .rst_n, .clkEn(1'h1), .waitMode, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .irq, .sckSense, .sckDrive, .sckDriveEn, .mosiSense,
		.mosiDrive, .mosiDriveEn, .misoSense, .misoDrive, .misoDriveEn, .selectSenseN,
		.selectDriveN, .selectDriveEn);
	scc_peer_model peer (.clock_polarity, .clock_phase, .lsb, .txByte(peerTx), .sck(sckSense),
		.mosi(mosiSense), .selN(selectSenseN), .miso(peerMiso), .rxByte(peerRx));
	// ==========================================
	// clock and hang guard
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	initial begin
		#200000;
		errors++;
		stop_test();
	end
	// ==========================================
	// bus cycles end one ns past the edge, so registered outputs have settled
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clock);
		regWr <= 1'h0;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clock);
		regRd <= 1'h0;
		#1 d = regRdData;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", nTests, errors);
		if (errors == 0 && nTests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		{rst_n, waitMode, regWr, regRd, regAddr, regWrData} = '0;
		{clock_polarity, clock_phase, lsb, peerTx} = '0;
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		rd(3'h0, rdv);
		`CHK("ctrl one reset", 8'h00, rdv)
		rd(3'h1, rdv);
		`CHK("ctrl two reset", 8'h00, rdv)
		wr(3'h1, 8'hFF);
		rd(3'h1, rdv);
		`CHK("ctrl two bits", 8'h1B, rdv)
		wr(3'h0, 8'hA5);
		rd(3'h0, rdv);
		`CHK("ctrl one", 8'hA5, rdv)
		`CHK("irq tx empty", 1'h1, irq)
		wr(3'h0, 8'h00);
		`CHK("irq off", 1'h0, irq)
		rd(3'h7, rdv);
		`CHK("unmapped", 8'h00, rdv)
		wr(3'h1, 8'h10);
		wr(3'h0, 8'h40);
		rd(3'h2, rdv);
		`CHK("slave status", 8'h20, rdv)
		wr(3'h0, 8'h00);
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			mv = 2'(m);
			cfg = {mv == 2'h1, 3'h5, mv[1], mv[0], 1'h1, ^mv};
			clock_polarity <= mv[1];
			clock_phase <= mv[0];
			lsb <= ^mv;
			peerTx <= 8'(8'hC1 + mv);
			wr(3'h1, (mv == 2'h2) ? 8'h12 : 8'h10);
			wr(3'h0, cfg);
			rd(3'h2, rdv);
			`CHK("tx empty", 8'h20, rdv)
			wr(3'h3, 8'(8'hA6 + mv));
			if (mv == 2'h2) begin
				@(posedge clock);
				waitMode <= 1'h1;
				repeat (40) @(posedge clock);
				waitMode <= 1'h0;
			end
			rdv = 8'h00;
			for (int k = 0; k < 200 && rdv[7] !== 1'h1; k++) rd(3'h2, rdv);
			`CHK("rx full", 1'h1, rdv[7])
			`CHK("irq rx", mv == 2'h1, irq)
			rd(3'h3, rdv);
			`CHK("master rx", 8'(8'hC1 + mv), rdv)
			`CHK("peer rx", 8'(8'hA6 + mv), peerRx)
			// the interrupt register follows the flag one cycle later
			@(posedge clock);
			#1;
			`CHK("irq cleared", 1'h0, irq)
			if (mv == 2'h0) begin
				rd(3'h4, rdv);
				`CHK("byte event", 1'h1, rdv[0])
				wr(3'h5, 8'h01);
				`CHK("irq unmasked", 1'h1, irq)
				wr(3'h4, 8'hFF);
				`CHK("irq w1c", 1'h0, irq)
				wr(3'h5, 8'h00);
			end
			wr(3'h0, cfg & 8'hBF);
			$display("mode %0d done", m);
		end
		wr(3'h1, 8'h19);
		wr(3'h0, 8'h52);
		wr(3'h1, 8'h18);
		wr(3'h1, 8'h11);
		wr(3'h0, 8'h12);
		`CHK("pins released", 4'h0, {sckDriveEn, mosiDriveEn, misoDriveEn, selectDriveEn})
		$display("pin test done");
		stop_test();
	end
endmodule
